/* verilog/acc_params.svh */
// Constants for the converter control block: register indices, fields, timing counts.
// Assumes a plain address/strobe register port with 8-bit registers.
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

// Register addresses
`define ACC_ADDR_CLK_CFG 4'h0
`define ACC_ADDR_REF_CFG 4'h1
`define ACC_ADDR_PWR_CFG 4'h2
`define ACC_ADDR_DAC_CFG 4'h3
`define ACC_ADDR_FIRST_CONVERTER_OUT_CODE 4'h4
`define ACC_ADDR_SECOND_CONVERTER_OUT_CODE 4'h5
`define ACC_ADDR_STATUS 4'h6
`define ACC_ADDR_RESULT 4'h7

// Reset values
`define ACC_CLK_CFG_RST 2'h0
`define ACC_SPEED_RST 2'h2
`define ACC_REF_RST 2'h0
`define ACC_CODE_RST 8'h00

// Clock select codes
`define ACC_CLK_RING 2'h0
`define ACC_CLK_ROUTED 2'h1
`define ACC_CLK_RC 2'h2
`define ACC_CLK_SERIAL 2'h3

// Reference select codes
`define ACC_REF_INTERNAL 2'h0
`define ACC_REF_RESERVED 2'h1
`define ACC_REF_QUARTER 2'h2
`define ACC_REF_NONE 2'h3

// Conversion timing in converter clock cycles
`define ACC_CONV_CYCLES 5'h10
`define ACC_SER_START 5'h06
`define ACC_PAR_START 5'h0A
`define ACC_RESULT_BITS 4'h8

// Power-on times in ns, and cycles at the 100 ns system clock
`define ACC_CLK_PERIOD_NS 100
`define ACC_SLOW_ON_NS 500000
`define ACC_FAST_ON_NS 5000
`define ACC_SLOW_ON_CYC (`ACC_SLOW_ON_NS / `ACC_CLK_PERIOD_NS)
`define ACC_FAST_ON_CYC (`ACC_FAST_ON_NS / `ACC_CLK_PERIOD_NS)

`endif

/* verilog/acc_pkg.sv */
// Types shared by the converter control block.
// Assumes acc_params.svh holds every number but the state encodings and code width below.
package acc_pkg;
	typedef enum logic [3:0] {
		ACC_IDLE = 4'b0001,
		ACC_WAIT = 4'b0010,
		ACC_SHIFT = 4'b0100,
		ACC_DONE = 4'b1000
	} acc_conv_e;
	typedef logic [7:0] acc_code_t;
endpackage

/* verilog/acc_converter_control.sv */
// Converter control: clock and reference select, power sequencing, result output, DACs.
// Assumes one system clock; converter clock arrives as synchronous sampled inputs.
// Functional notes
// - Two-bit select picks ring, routed, RC or serial-port clock as converter clock.
// - One conversion spans sixteen converter clock cycles; a parallel conversion here spans nineteen.
// - High power-down request powers down converter and gain stage.
// - Force bit clear: request switches whole analog macrocell, slow power-on.
// - Force bit set: request switches converter core only, fast power-on.
// - First power-on about 500 us; later core-only power-on under 5 us.
// - Serial result bits start six converter clocks after the request.
// - Parallel result starts ten converter clocks after the request.
// - Both paths give eight result bits over sixteen clocks, serially shiftable; the parallel result here stays valid until clock eighteen.
// - Reference select: 00 internal, 10 quarter supply, 01 reserved, 11 none.
// - Each DAC has a power enable, 1 powered; the second DAC powers only while the first DAC's enable is also set.
// - First DAC input select: 0 register code, 1 comparator-unit input.
// - Second DAC input select: 0 comparator negative input, 1 register code.
// - First DAC code maps linearly, 00 to 0 V, FF to 1 V.
// - Second DAC code maps reference bottom to reference top.
// - Enabling converter powers the gain stage too.
`include "acc_params.svh"

module acc_converter_control #(
	parameter int SLOW_ON_CYCLES = `ACC_SLOW_ON_CYC,
	parameter int FAST_ON_CYCLES = `ACC_FAST_ON_CYC
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [7:0] reg_rdata_o,
	input wire logic ring_osc_i,
	input wire logic routed_clock_input_i,
	input wire logic rc_osc_i,
	input wire logic serial_port_clk_i,
	input wire logic power_down_route_i,
	input wire logic parallel_mode_i,
	input wire logic [7:0] sample_code_i,
	input wire acc_pkg::acc_code_t comparator_unit_in_i,
	input wire acc_pkg::acc_code_t comparator_unit_neg_i,
	output logic converter_clk_o,
	output logic [1:0] reference_sel_o,
	output logic converter_power_o,
	output logic gain_stage_power_o,
	output logic analog_macro_power_o,
	output logic converter_ready_o,
	output logic serial_result_out_o,
	output logic serial_valid_o,
	output acc_pkg::acc_code_t parallel_result_out_o,
	output logic parallel_valid_o,
	output logic first_converter_power_o,
	output logic second_converter_power_o,
	output acc_pkg::acc_code_t first_converter_out_o,
	output acc_pkg::acc_code_t second_converter_out_o
);
	import acc_pkg::*;

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	logic [1:0] converter_clock_select;
	logic [1:0] converter_speed_select;
	logic [1:0] reference_source_select;
	logic wake_sleep_enable;
	logic force_analog_on;
	logic first_dac_power;
	logic second_dac_power;
	logic first_dac_input_select;
	logic second_dac_input_select;
	acc_code_t first_dac_code;
	acc_code_t second_dac_code;
	acc_code_t result;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			converter_clock_select <= `ACC_CLK_CFG_RST;
			converter_speed_select <= `ACC_SPEED_RST;
			reference_source_select <= `ACC_REF_RST;
			wake_sleep_enable <= 1'b0;
			force_analog_on <= 1'b0;
			first_dac_power <= 1'b0;
			second_dac_power <= 1'b0;
			first_dac_input_select <= 1'b0;
			second_dac_input_select <= 1'b0;
			first_dac_code <= `ACC_CODE_RST;
			second_dac_code <= `ACC_CODE_RST;
		end else if (reg_write_i) begin
			unique case (reg_addr_i)
				`ACC_ADDR_CLK_CFG: begin
					converter_clock_select <= reg_wdata_i[1:0];
					converter_speed_select <= reg_wdata_i[3:2];
				end
				`ACC_ADDR_REF_CFG: reference_source_select <= reg_wdata_i[1:0];
				`ACC_ADDR_PWR_CFG: begin
					wake_sleep_enable <= reg_wdata_i[0];
					force_analog_on <= reg_wdata_i[1];
				end
				`ACC_ADDR_DAC_CFG: begin
					first_dac_power <= reg_wdata_i[0];
					second_dac_power <= reg_wdata_i[1];
					first_dac_input_select <= reg_wdata_i[2];
					second_dac_input_select <= reg_wdata_i[3];
				end
				`ACC_ADDR_FIRST_CONVERTER_OUT_CODE: first_dac_code <= reg_wdata_i;
				`ACC_ADDR_SECOND_CONVERTER_OUT_CODE: second_dac_code <= reg_wdata_i;
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Converter clock select and synchronisers
	// ----------------------------------------------------------------
	logic sel_clk;
	always_comb begin
		unique case (converter_clock_select)
			`ACC_CLK_RING: sel_clk = ring_osc_i;
			`ACC_CLK_ROUTED: sel_clk = routed_clock_input_i;
			`ACC_CLK_RC: sel_clk = rc_osc_i;
			`ACC_CLK_SERIAL: sel_clk = serial_port_clk_i;
		endcase
	end
	assign converter_clk_o = sel_clk;

	logic clk_q;
	logic clk_rise;
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			clk_q <= 1'b0;
		end else begin
			clk_q <= sel_clk;
		end
	end
	assign clk_rise = sel_clk & ~clk_q;

	// Request sampled on converter clock rising edges
	logic pd_meta;
	logic pd_sync;
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			pd_meta <= 1'b0;
			pd_sync <= 1'b0;
		end else if (clk_rise) begin
			pd_meta <= power_down_route_i;
			pd_sync <= pd_meta;
		end
	end

	// ----------------------------------------------------------------
	// Power sequencing
	// ----------------------------------------------------------------
	logic macro_on;
	logic ever_on;
	logic [31:0] on_cnt;
	always_comb begin
		converter_power_o = ~pd_sync;
		gain_stage_power_o = ~pd_sync;
		macro_on = force_analog_on | ~pd_sync;
	end
	assign analog_macro_power_o = macro_on;
	assign reference_sel_o = reference_source_select;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			on_cnt <= 32'h0;
			ever_on <= 1'b0;
			converter_ready_o <= 1'b0;
		end else if (pd_sync) begin
			on_cnt <= 32'h0;
			converter_ready_o <= 1'b0;
			if (!macro_on) begin
				ever_on <= 1'b0;
			end
		end else if (!converter_ready_o) begin
			on_cnt <= on_cnt + 32'h1;
			if (on_cnt + 32'h1 >= 32'(ever_on ? FAST_ON_CYCLES : SLOW_ON_CYCLES)) begin
				converter_ready_o <= 1'b1;
				ever_on <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Conversion sequence
	// ----------------------------------------------------------------
	acc_conv_e state;
	acc_conv_e next_state;
	logic pd_prev;
	logic [4:0] cyc;
	logic [3:0] bit_idx;
	logic par_mode;
	acc_code_t shreg;
	logic [4:0] start_cyc;
	logic shift_bit;

	assign start_cyc = par_mode ? `ACC_PAR_START : `ACC_SER_START;

	// Top bit leaves before the first shift; later bits trail the shifter by one
	assign shift_bit = (state == ACC_SHIFT) ? shreg[6] : shreg[7];

	always_comb begin
		next_state = state;
		unique case (state)
			ACC_IDLE: if (pd_sync & ~pd_prev) next_state = ACC_WAIT;
			ACC_WAIT: if (cyc == start_cyc - 5'h1) next_state = ACC_SHIFT;
			ACC_SHIFT: if (bit_idx == `ACC_RESULT_BITS - 4'h1) next_state = ACC_DONE;
			// Parallel word overruns the sixteenth edge, so end on reaching it or later
			ACC_DONE: if (cyc >= `ACC_CONV_CYCLES - 5'h1) next_state = ACC_IDLE;
			default: next_state = ACC_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			state <= ACC_IDLE;
			pd_prev <= 1'b0;
			cyc <= 5'h0;
			bit_idx <= 4'h0;
			par_mode <= 1'b0;
			shreg <= `ACC_CODE_RST;
		end else if (clk_rise) begin
			state <= next_state;
			pd_prev <= pd_sync;
			if (state == ACC_IDLE) begin
				cyc <= 5'h0;
				bit_idx <= 4'h0;
				par_mode <= parallel_mode_i;
				shreg <= sample_code_i;
			end else begin
				cyc <= cyc + 5'h1;
				if (state == ACC_SHIFT) begin
					bit_idx <= bit_idx + 4'h1;
					shreg <= {shreg[6:0], 1'b0};
				end
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			serial_result_out_o <= 1'b0;
			serial_valid_o <= 1'b0;
			parallel_result_out_o <= `ACC_CODE_RST;
			parallel_valid_o <= 1'b0;
			result <= `ACC_CODE_RST;
		end else if (clk_rise) begin
			serial_valid_o <= (next_state == ACC_SHIFT) & ~par_mode;
			serial_result_out_o <= (next_state == ACC_SHIFT) ? shift_bit : 1'b0;
			parallel_valid_o <= (next_state == ACC_SHIFT) & par_mode;
			if (state == ACC_WAIT && next_state == ACC_SHIFT) begin
				parallel_result_out_o <= shreg;
				result <= shreg;
			end
		end
	end

	// ----------------------------------------------------------------
	// DAC paths
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			first_converter_power_o <= 1'b0;
			second_converter_power_o <= 1'b0;
			first_converter_out_o <= `ACC_CODE_RST;
			second_converter_out_o <= `ACC_CODE_RST;
		end else begin
			first_converter_power_o <= first_dac_power;
			second_converter_power_o <= first_dac_power & second_dac_power;
			first_converter_out_o <= first_dac_input_select ?
				comparator_unit_in_i : first_dac_code;
			second_converter_out_o <= second_dac_input_select ?
				second_dac_code : comparator_unit_neg_i;
		end
	end

	// ----------------------------------------------------------------
	// Register read port
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_read_i) begin
			unique case (reg_addr_i)
				`ACC_ADDR_CLK_CFG: reg_rdata_o <= {4'h0, converter_speed_select,
					converter_clock_select};
				`ACC_ADDR_REF_CFG: reg_rdata_o <= {6'h00, reference_source_select};
				`ACC_ADDR_PWR_CFG: reg_rdata_o <= {6'h00, force_analog_on, wake_sleep_enable};
				`ACC_ADDR_DAC_CFG: reg_rdata_o <= {4'h0, second_dac_input_select,
					first_dac_input_select, second_dac_power, first_dac_power};
				`ACC_ADDR_FIRST_CONVERTER_OUT_CODE: reg_rdata_o <= first_dac_code;
				`ACC_ADDR_SECOND_CONVERTER_OUT_CODE: reg_rdata_o <= second_dac_code;
				`ACC_ADDR_STATUS: reg_rdata_o <= {4'h0, state != ACC_IDLE,
					converter_ready_o, macro_on, pd_sync};
				`ACC_ADDR_RESULT: reg_rdata_o <= result;
				default: reg_rdata_o <= 8'h00;
			endcase
		end else begin
			reg_rdata_o <= 8'h00;
		end
	end
endmodule // acc_converter_control

/* tb/acc_conv_sva.sv */
// Checker for the converter control block, bound to its ports.
// Assumes one core clock, converter clock sampled in that domain.
module acc_conv_sva #(
	parameter int SLOW_ON_CYCLES = 5000,
	parameter int FAST_ON_CYCLES = 50
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic power_down_route_i,
	input wire logic converter_clk_o,
	input wire logic converter_power_o,
	input wire logic gain_stage_power_o,
	input wire logic analog_macro_power_o,
	input wire logic converter_ready_o,
	input wire logic serial_valid_o,
	input wire logic parallel_valid_o,
	input wire logic first_converter_power_o,
	input wire logic second_converter_power_o
);
	localparam int SLOW_LIM = SLOW_ON_CYCLES + 4;
	logic [3:0] edges;
	int on_age;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	// ----
	// Converter clock edges inside a serial word
	// ----
	always_ff @(posedge core_clk_i) begin
		if (rst_i || !serial_valid_o) edges <= 4'h0;
		else if ($rose(converter_clk_o)) edges <= edges + 4'h1;
	end
	// Cycles spent powered but not yet ready
	always_ff @(posedge core_clk_i) begin
		if (rst_i || !converter_power_o || converter_ready_o) on_age <= 0;
		else on_age <= on_age + 1;
	end
	a_gain_tracks_core: assert property (gain_stage_power_o == converter_power_o)
		else $error("gain stage power differs from converter power");
	a_macro_over_core: assert property (converter_power_o |-> analog_macro_power_o)
		else $error("converter powered without analog macro");
	a_pd_powers_down: assert property ($rose(power_down_route_i) |-> ##[1:40] !converter_power_o)
		else $error("request did not power down converter");
	a_dac_pair_power: assert property (second_converter_power_o |-> first_converter_power_o)
		else $error("second converter powered alone");
	a_one_result_path: assert property (!(serial_valid_o && parallel_valid_o))
		else $error("serial and parallel results at once");
	a_serial_in_down: assert property ($rose(serial_valid_o) |-> !converter_power_o)
		else $error("serial result outside power-down");
	a_serial_eight_bits: assert property ($fell(serial_valid_o) |-> edges == 4'h8)
		else $error("serial word not eight clocks long");
	a_ready_bound: assert property (on_age <= SLOW_LIM)
		else $error("converter not ready in time");
	a_ready_when_on: assert property ($rose(converter_ready_o) |-> converter_power_o)
		else $error("ready while powered down");
	c_serial: cover property ($rose(serial_valid_o));
	c_parallel: cover property ($rose(parallel_valid_o));
	c_ready: cover property ($rose(converter_ready_o));
endmodule // acc_conv_sva

bind acc_converter_control acc_conv_sva #(.SLOW_ON_CYCLES(SLOW_ON_CYCLES),
	.FAST_ON_CYCLES(FAST_ON_CYCLES)) u_sva (.core_clk_i, .rst_i, .power_down_route_i,
	.converter_clk_o, .converter_power_o, .gain_stage_power_o, .analog_macro_power_o,
	.converter_ready_o, .serial_valid_o, .parallel_valid_o, .first_converter_power_o,
	.second_converter_power_o);

/* tb/acc_partner.sv */
// Far side model: clock sources, power-down request, serial reader.
// Assumes ring source selected while converting, eight core cycles a bit.
module acc_partner (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic go_i,
	input wire logic serial_result_out_i,
	input wire logic serial_valid_i,
	output logic [3:0] osc_o,
	output logic pd_o,
	output logic [7:0] word_o,
	output logic word_stb_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [5:0] cnt;
	logic [8:0] hold;
	logic [7:0] sc;
	assign osc_o = cnt[5:2];
	always_ff @(posedge core_clk_i) begin
		cnt <= rst_i ? 6'h00 : cnt + 6'h01;
	end
	// Request held forty converter periods, spaced well apart
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			pd_o <= 1'b0;
			hold <= 9'h000;
		end else if (go_i) begin
			pd_o <= 1'b1;
			hold <= 9'h140;
		end else if (hold != 9'h000) begin
			hold <= hold - 9'h001;
			pd_o <= (hold != 9'h001);
		end
	end
	// Mid-bit sampling, first bit into the top
	always_ff @(posedge core_clk_i) begin
		word_stb_o <= 1'b0;
		if (rst_i) begin
			sc <= 8'h00;
		end else if (serial_valid_i) begin
			sc <= sc + 8'h01;
			if (sc[2:0] == 3'h3) word_o <= {word_o[6:0], serial_result_out_i};
		end else if (sc != 8'h00) begin
			sc <= 8'h00;
			word_stb_o <= 1'b1;
		end
	end
endmodule // acc_partner

/* tb/tb_adc_dac_converter_control.sv */
// Testbench: registers, DAC routing, clock select, conversions.
// Assumes partner model and bound checker.
module tb_adc_dac_converter_control;
	timeunit 1ns;
	timeprecision 1ns;
	import acc_pkg::*;
	logic core_clk_i = 1'b0, rst_i = 1'b1, wr_s = 1'b0, rd_s = 1'b0, par_m = 1'b0, go = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00, rdata, word;
	acc_code_t code = 8'h00, cin = 8'h00, cneg = 8'h00, pres, o0, o1, dv;
	logic [1:0] rsel;
	logic [3:0] osc;
	logic cclk, cpw, gpw, mpw, rdy, sdo, sval, pval, p0, p1, pd, wstb, rd_pend = 0, pv_q = 0;
	logic [7:0] q[$];
	int miscompares = 0, checks_done = 0;
	always #50 core_clk_i = ~core_clk_i;
	acc_converter_control #(.SLOW_ON_CYCLES(20), .FAST_ON_CYCLES(5)) u_dut (.core_clk_i,
		.rst_i, .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_write_i(wr_s), .reg_read_i(rd_s),
		.reg_rdata_o(rdata), .ring_osc_i(osc[0]), .routed_clock_input_i(osc[1]),
		.rc_osc_i(osc[2]), .serial_port_clk_i(osc[3]), .power_down_route_i(pd),
		.parallel_mode_i(par_m), .sample_code_i(code), .comparator_unit_in_i(cin),
		.comparator_unit_neg_i(cneg), .converter_clk_o(cclk), .reference_sel_o(rsel),
		.converter_power_o(cpw), .gain_stage_power_o(gpw), .analog_macro_power_o(mpw),
		.converter_ready_o(rdy), .serial_result_out_o(sdo), .serial_valid_o(sval),
		.parallel_result_out_o(pres), .parallel_valid_o(pval), .first_converter_power_o(p0),
		.second_converter_power_o(p1), .first_converter_out_o(o0),
		.second_converter_out_o(o1));
	acc_partner u_far (.core_clk_i, .rst_i, .go_i(go), .serial_result_out_i(sdo),
		.serial_valid_i(sval), .osc_o(osc), .pd_o(pd), .word_o(word), .word_stb_o(wstb));
	// ----
	// Shared tasks
	// ----
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge core_clk_i);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge core_clk_i);
		addr <= a;
		rd_s <= 1'b1;
		q.push_back(e);
		@(posedge core_clk_i);
		rd_s <= 1'b0;
	endtask
	task automatic conv(input logic par, input logic frc);
		int n, t;
		wr(4'h2, {6'h00, frc, 1'b0});
		code <= $urandom;
		par_m <= par;
		repeat (4) @(posedge core_clk_i);
		q.push_back(code);
		go <= 1'b1;
		@(posedge core_clk_i);
		go <= 1'b0;
		repeat (100) @(negedge core_clk_i);
		chk(cpw, 1'b0);
		chk(gpw, 1'b0);
		chk(mpw, frc);
		n = 0;
		t = 0;
		while (rdy !== 1'b1 && t < 900) begin
			@(negedge core_clk_i);
			t++;
			if (cpw === 1'b1) n++;
		end
		chk(n >= (frc ? 2 : 17) && n <= (frc ? 8 : 23), 1'b1);
		rd(4'h7, code);
		$display("test conversion par=%0d force=%0d done", par, frc);
	endtask
	task automatic give_verdict();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// ----
	// Result watcher
	// ----
	always @(negedge core_clk_i) begin
		if (rd_pend) chk(rdata, q.pop_front());
		if (wstb) chk(word, q.pop_front());
		if (pval && !pv_q) chk(pres, q.pop_front());
		rd_pend = rd_s;
		pv_q = pval;
	end
	initial begin
		repeat (12000) @(posedge core_clk_i);
		miscompares++;
		give_verdict();
	end
	// ----
	// Main sequence
	// ----
	initial begin
		void'($urandom(49));
		repeat (5) @(posedge core_clk_i);
		rst_i <= 1'b0;
		rd(4'h0, 8'h08);
		for (int i = 1; i < 16; i++) if (i != 6 && i != 7) rd(i[3:0], 8'h00);
		$display("test reset values done");
		for (int r = 0; r < 4; r++) begin
			wr(4'h1, r[7:0]);
			@(negedge core_clk_i);
			chk(rsel, r[7:0]);
		end
		$display("test reference select done");
		@(posedge core_clk_i);
		cin <= $urandom;
		cneg <= $urandom;
		dv = $urandom;
		wr(4'h4, dv);
		rd(4'h4, dv);
		wr(4'h5, ~dv);
		for (int v = 0; v < 16; v++) begin
			wr(4'h3, v[7:0]);
			repeat (2) @(negedge core_clk_i);
			chk(p0, v[0]);
			chk(p1, v[0] & v[1]);
			chk(o0, v[2] ? cin : dv);
			chk(o1, v[3] ? ~dv : cneg);
		end
		wr(4'h3, 8'h00);
		$display("test converter routing done");
		for (int s = 0; s < 4; s++) begin
			wr(4'h0, 8'h08 | s[7:0]);
			repeat (40) begin
				@(negedge core_clk_i);
				chk(cclk, osc[s]);
			end
		end
		wr(4'h0, 8'h08);
		$display("test clock select done");
		conv(1'b0, 1'b0);
		conv(1'b0, 1'b1);
		conv(1'b1, 1'b1);
		conv(1'b1, 1'b0);
		give_verdict();
	end
endmodule // tb_adc_dac_converter_control
